// ---- pkg/spma_defines.svh ----
// Constants of the sensor parameter access block
// What this block does
// - Trigger 0/1/2; period only in interval
// - Filter 0..4; custom lengths only in custom
// - Invalid reading: last, near or far
// - Hold analog output for programmed milliseconds
// - Switch point/window; polarity low or high
// - Zero signed um, limited to end*1000
// - Other interfaces read-only during Modbus use
// - One connection; rate may drop meanwhile
// - Answer only port 502, unit 1
// - Support function codes 02,03,04,06,16
// - Three tables decoded independently
// - Register count must equal parameter length
// - Low word at lower address
// - Parameter writes need configuration mode first
// - Write status 1 ok, 2 error, 3 busy
`ifndef SPMA_DEFINES_SVH
`define SPMA_DEFINES_SVH
`define SPMA_TCP_PORT     16'h01F6
`define SPMA_UNIT_ID      8'h01
`define SPMA_FC_RD_DI     8'h02
`define SPMA_FC_RD_HR     8'h03
`define SPMA_FC_RD_IR     8'h04
`define SPMA_FC_WR_ONE    8'h06
`define SPMA_FC_WR_MANY   8'h10
`define SPMA_EXC_FUNC     8'h01
`define SPMA_EXC_ADDR     8'h02
`define SPMA_EXC_VALUE    8'h03
`define SPMA_HR_ENTER     16'h0000
`define SPMA_HR_LEAVE     16'h0001
`define SPMA_HR_ZERO      16'h0004
`define SPMA_HR_TRIG      16'h000D
`define SPMA_HR_PERIOD    16'h000E
`define SPMA_HR_RSTART    16'h000F
`define SPMA_HR_REND      16'h0010
`define SPMA_HR_FILT      16'h0011
`define SPMA_HR_MED       16'h0012
`define SPMA_HR_AVG       16'h0013
`define SPMA_HR_INV       16'h0014
`define SPMA_HR_HOLD      16'h0015
`define SPMA_HR_SW        16'h0016
`define SPMA_HR_FAR       16'h0017
`define SPMA_HR_NEAR      16'h0018
`define SPMA_HR_HYST      16'h0019
`define SPMA_HR_POL       16'h001A
`define SPMA_DI_CFG       16'h0000
`define SPMA_DI_OTHER     16'h0001
`define SPMA_IR_STATUS    16'h0000
`define SPMA_WS_OK        16'h0001
`define SPMA_WS_ERR       16'h0002
`define SPMA_WS_BUSY      16'h0003
`define SPMA_TRIG_MAX     16'h0002
`define SPMA_TRIG_INTV    16'h0002
`define SPMA_FILT_MAX     16'h0004
`define SPMA_FILT_CUSTOM  16'h0004
`define SPMA_INV_LAST     16'h0000
`define SPMA_INV_NEAR     16'h0001
`define SPMA_INV_FAR      16'h0002
`define SPMA_SW_POINT     16'h0001
`define SPMA_SW_WINDOW    16'h0002
`define SPMA_POL_MAX      16'h0001
`define SPMA_ZERO_SCALE   32'h000003E8
`define SPMA_MS_NS        1000000
`define SPMA_CLK_NS       8
`endif

// ---- pkg/spma_pkg.sv ----
// Types of the sensor parameter access block
package spma_pkg;
  typedef struct packed {
    logic        valid;
    logic [15:0] port;
    logic [7:0]  unit;
    logic [7:0]  fc;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [31:0] wdata;
  } spma_req_s;
  typedef struct packed {
    logic        valid;
    logic        exc;
    logic [7:0]  fc;
    logic [7:0]  code;
    logic [15:0] qty;
    logic [31:0] rdata;
  } spma_rsp_s;
  typedef struct packed {
    logic [15:0] trig;
    logic [31:0] period;
    logic [31:0] rstart;
    logic [31:0] rend;
    logic [31:0] zero;
    logic [15:0] filt;
    logic [15:0] med;
    logic [15:0] avg;
    logic [15:0] inv;
    logic [15:0] hold;
    logic [15:0] sw;
    logic [31:0] far;
    logic [31:0] near;
    logic [31:0] hyst;
    logic [15:0] pol;
  } spma_par_s;
  typedef enum logic [1:0] {SPMA_CLOSED, SPMA_OPEN, SPMA_CONFIG} spma_link_e;
endpackage

// ---- rtl/spma_top.sv ----
// Modbus parameter front end with measurement post-processing
`timescale 1ns/10ps
`include "spma_defines.svh"
module spma_top #(
  parameter int MS_CYC = `SPMA_MS_NS / `SPMA_CLK_NS
) (
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                ce_i,
  input  wire logic                conn_open_i,
  input  wire logic                conn_close_i,
  input  wire logic                other_cfg_i,
  input  wire spma_pkg::spma_req_s req_i,
  input  wire logic [31:0]         meas_i,
  input  wire logic                meas_valid_i,
  output spma_pkg::spma_rsp_s      rsp_o,
  output spma_pkg::spma_par_s      par_o,
  output logic                     conn_refused_o,
  output logic                     others_ro_o,
  output logic                     rate_reduce_o,
  output logic [15:0]              wr_status_o,
  output logic [31:0]              eff_period_o,
  output logic [15:0]              eff_median_o,
  output logic [15:0]              eff_average_o,
  output logic [31:0]              dist_o,
  output logic                     hold_o,
  output logic                     switch_o
);
  import spma_pkg::*;
  // Register length of each holding address, zero when unmapped
  function automatic logic [15:0] hr_len(input logic [15:0] a);
    case (a)
      `SPMA_HR_ENTER, `SPMA_HR_LEAVE, `SPMA_HR_TRIG, `SPMA_HR_FILT, `SPMA_HR_MED,
      `SPMA_HR_AVG, `SPMA_HR_INV, `SPMA_HR_HOLD, `SPMA_HR_SW, `SPMA_HR_POL: hr_len = 16'h0001;
      `SPMA_HR_ZERO, `SPMA_HR_PERIOD, `SPMA_HR_RSTART, `SPMA_HR_REND,
      `SPMA_HR_FAR, `SPMA_HR_NEAR, `SPMA_HR_HYST: hr_len = 16'h0002;
      default: hr_len = 16'h0000;
    endcase
  endfunction
  // Parameter value behind a holding address, low word in bits 15:0
  function automatic logic [31:0] hr_read(input spma_par_s p, input logic [15:0] a);
    case (a)
      `SPMA_HR_ZERO:   hr_read = p.zero;
      `SPMA_HR_TRIG:   hr_read = {16'h0000, p.trig};
      `SPMA_HR_PERIOD: hr_read = p.period;
      `SPMA_HR_RSTART: hr_read = p.rstart;
      `SPMA_HR_REND:   hr_read = p.rend;
      `SPMA_HR_FILT:   hr_read = {16'h0000, p.filt};
      `SPMA_HR_MED:    hr_read = {16'h0000, p.med};
      `SPMA_HR_AVG:    hr_read = {16'h0000, p.avg};
      `SPMA_HR_INV:    hr_read = {16'h0000, p.inv};
      `SPMA_HR_HOLD:   hr_read = {16'h0000, p.hold};
      `SPMA_HR_SW:     hr_read = {16'h0000, p.sw};
      `SPMA_HR_FAR:    hr_read = p.far;
      `SPMA_HR_NEAR:   hr_read = p.near;
      `SPMA_HR_HYST:   hr_read = p.hyst;
      `SPMA_HR_POL:    hr_read = {16'h0000, p.pol};
      default:         hr_read = 32'h00000000;
    endcase
  endfunction
  // Value check before a parameter write is applied
  function automatic logic wr_ok(input spma_par_s p, input logic [15:0] a, input logic [31:0] d);
    logic [31:0] mag;
    logic [63:0] lim;
    mag = d[31] ? 32'(-d) : d;
    lim = 64'(p.rend) * 64'(`SPMA_ZERO_SCALE);
    case (a)
      `SPMA_HR_TRIG: wr_ok = d[15:0] <= `SPMA_TRIG_MAX;
      `SPMA_HR_FILT: wr_ok = d[15:0] <= `SPMA_FILT_MAX;
      `SPMA_HR_INV:  wr_ok = d[15:0] <= `SPMA_INV_FAR;
      `SPMA_HR_SW:   wr_ok = d[15:0] == `SPMA_SW_POINT || d[15:0] == `SPMA_SW_WINDOW;
      `SPMA_HR_POL:  wr_ok = d[15:0] <= `SPMA_POL_MAX;
      `SPMA_HR_ZERO: wr_ok = 64'(mag) <= lim;
      default:       wr_ok = 1'b1;
    endcase
  endfunction
  spma_link_e  link_reg, link_next;
  spma_par_s   par_reg, par_next;
  spma_rsp_s   rsp_reg, rsp_next;
  logic [15:0] ws_reg, ws_next;
  logic        pend_reg, pend_next;
  logic        refu_reg, refu_next;
  logic [15:0] q;
  logic [15:0] len;
  logic        take;
  // Request decode; the session state gates every parameter write
  always_comb begin
    link_next = link_reg;
    par_next  = par_reg;
    ws_next   = pend_reg ? `SPMA_WS_OK : ws_reg;
    pend_next = 1'b0;
    refu_next = 1'b0;
    rsp_next  = '0;
    q         = (req_i.fc == `SPMA_FC_WR_ONE) ? 16'h0001 : req_i.qty;
    len       = hr_len(req_i.addr);
    if (conn_open_i) begin
      if (link_reg == SPMA_CLOSED) link_next = SPMA_OPEN;
      else refu_next = 1'b1;
    end
    take = req_i.valid && link_reg != SPMA_CLOSED && req_i.port == `SPMA_TCP_PORT && req_i.unit == `SPMA_UNIT_ID;
    if (take) begin
      rsp_next.valid = 1'b1;
      rsp_next.fc    = req_i.fc;
      rsp_next.qty   = q;
      rsp_next.exc   = 1'b1;
      case (req_i.fc)
        `SPMA_FC_RD_DI: begin
          if (req_i.addr > `SPMA_DI_OTHER) rsp_next.code = `SPMA_EXC_ADDR;
          else if (q != 16'h0001) rsp_next.code = `SPMA_EXC_VALUE;
          else begin
            rsp_next.exc   = 1'b0;
            rsp_next.rdata = {31'h00000000, req_i.addr[0] ? other_cfg_i : (link_reg == SPMA_CONFIG)};
          end
        end
        `SPMA_FC_RD_IR: begin
          if (req_i.addr != `SPMA_IR_STATUS) rsp_next.code = `SPMA_EXC_ADDR;
          else if (q != 16'h0001) rsp_next.code = `SPMA_EXC_VALUE;
          else begin
            rsp_next.exc   = 1'b0;
            rsp_next.rdata = {16'h0000, ws_reg};
          end
        end
        `SPMA_FC_RD_HR: begin
          if (len == 16'h0000 || req_i.addr <= `SPMA_HR_LEAVE) rsp_next.code = `SPMA_EXC_ADDR;
          else if (q != len) rsp_next.code = `SPMA_EXC_VALUE;
          else begin
            rsp_next.exc   = 1'b0;
            rsp_next.rdata = hr_read(par_reg, req_i.addr);
          end
        end
        `SPMA_FC_WR_ONE, `SPMA_FC_WR_MANY: begin
          if (len == 16'h0000) rsp_next.code = `SPMA_EXC_ADDR;
          else if (q != len) rsp_next.code = `SPMA_EXC_VALUE;
          else if (req_i.addr == `SPMA_HR_ENTER) begin
            if (other_cfg_i) begin
              rsp_next.code = `SPMA_EXC_FUNC;
              ws_next       = `SPMA_WS_ERR;
            end else begin
              rsp_next.exc = 1'b0;
              link_next    = SPMA_CONFIG;
            end
          end else if (req_i.addr == `SPMA_HR_LEAVE) begin
            rsp_next.exc = 1'b0;
            link_next    = SPMA_OPEN;
          end else if (link_reg != SPMA_CONFIG || other_cfg_i) begin
            rsp_next.code = `SPMA_EXC_FUNC;
            ws_next       = `SPMA_WS_ERR;
          end else if (!wr_ok(par_reg, req_i.addr, req_i.wdata)) begin
            rsp_next.code = `SPMA_EXC_VALUE;
            ws_next       = `SPMA_WS_ERR;
          end else begin
            rsp_next.exc = 1'b0;
            ws_next      = `SPMA_WS_BUSY;
            pend_next    = 1'b1;
            case (req_i.addr)
              `SPMA_HR_ZERO:   par_next.zero   = req_i.wdata;
              `SPMA_HR_TRIG:   par_next.trig   = req_i.wdata[15:0];
              `SPMA_HR_PERIOD: par_next.period = req_i.wdata;
              `SPMA_HR_RSTART: par_next.rstart = req_i.wdata;
              `SPMA_HR_REND:   par_next.rend   = req_i.wdata;
              `SPMA_HR_FILT:   par_next.filt   = req_i.wdata[15:0];
              `SPMA_HR_MED:    par_next.med    = req_i.wdata[15:0];
              `SPMA_HR_AVG:    par_next.avg    = req_i.wdata[15:0];
              `SPMA_HR_INV:    par_next.inv    = req_i.wdata[15:0];
              `SPMA_HR_HOLD:   par_next.hold   = req_i.wdata[15:0];
              `SPMA_HR_SW:     par_next.sw     = req_i.wdata[15:0];
              `SPMA_HR_FAR:    par_next.far    = req_i.wdata;
              `SPMA_HR_NEAR:   par_next.near   = req_i.wdata;
              `SPMA_HR_HYST:   par_next.hyst   = req_i.wdata;
              `SPMA_HR_POL:    par_next.pol    = req_i.wdata[15:0];
              default:         par_next.pol    = par_reg.pol;
            endcase
          end
        end
        default: rsp_next.code = `SPMA_EXC_FUNC;
      endcase
      if (!rsp_next.exc) rsp_next.code = 8'h00;
    end
    // Close last, so a request in the same cycle cannot reopen the session
    if (conn_close_i) link_next = SPMA_CLOSED;
  end
  // Session and parameter registers; point mode is the safe reset choice
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      link_reg    <= SPMA_CLOSED;
      par_reg     <= '0;
      par_reg.sw  <= `SPMA_SW_POINT;
      rsp_reg     <= '0;
      ws_reg      <= `SPMA_WS_OK;
      pend_reg    <= 1'b0;
      refu_reg    <= 1'b0;
    end else if (ce_i) begin
      link_reg <= link_next;
      par_reg  <= par_next;
      rsp_reg  <= rsp_next;
      ws_reg   <= ws_next;
      pend_reg <= pend_next;
      refu_reg <= refu_next;
    end
  end
  logic [31:0] last_reg, last_next, dist_reg, dist_next;
  logic [16:0] tick_reg, tick_next;
  logic [15:0] left_reg, left_next;
  logic        wasv_reg, wasv_next, sw_reg, sw_next, hold_reg, hold_next;
  logic        act;
  // Measurement post-processing; hysteresis is stored but not yet applied
  always_comb begin
    last_next = last_reg;
    dist_next = dist_reg;
    tick_next = tick_reg;
    left_next = left_reg;
    wasv_next = wasv_reg;
    if (meas_valid_i) begin
      last_next = meas_i;
      dist_next = meas_i;
      wasv_next = 1'b1;
      left_next = 16'h0000;
    end else begin
      case (par_reg.inv)
        `SPMA_INV_NEAR: dist_next = par_reg.rstart;
        `SPMA_INV_FAR:  dist_next = par_reg.rend;
        default:        dist_next = last_reg;
      endcase
      if (wasv_reg) begin
        wasv_next = 1'b0;
        left_next = par_reg.hold;
        tick_next = 17'h00000;
      end else if (left_reg != 16'h0000) begin
        if (tick_reg == 17'(MS_CYC - 1)) begin
          tick_next = 17'h00000;
          left_next = left_reg - 16'h0001;
        end else begin
          tick_next = tick_reg + 17'h00001;
        end
      end
    end
    if (par_reg.sw == `SPMA_SW_WINDOW) act = dist_reg >= par_reg.near && dist_reg <= par_reg.far;
    else act = dist_reg <= par_reg.far;
    sw_next = (par_reg.pol == `SPMA_POL_MAX) ? act : !act;
    hold_next = left_next != 16'h0000; // Kept in a flop so the pin has no decode glitch
  end
  // Measurement registers
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      last_reg <= 32'h00000000;
      dist_reg <= 32'h00000000;
      tick_reg <= 17'h00000;
      left_reg <= 16'h0000;
      wasv_reg <= 1'b0;
      sw_reg   <= 1'b0;
      hold_reg <= 1'b0;
    end else if (ce_i) begin
      last_reg <= last_next;
      dist_reg <= dist_next;
      tick_reg <= tick_next;
      left_reg <= left_next;
      wasv_reg <= wasv_next;
      sw_reg   <= sw_next;
      hold_reg <= hold_next;
    end
  end
  logic [31:0] per_reg;
  logic [15:0] med_reg, avg_reg;
  logic        ro_reg, rate_reg;
  // Effective settings, registered so every output leaves a flip-flop
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      per_reg  <= 32'h00000000;
      med_reg  <= 16'h0000;
      avg_reg  <= 16'h0000;
      ro_reg   <= 1'b0;
      rate_reg <= 1'b0;
    end else if (ce_i) begin
      per_reg  <= (par_next.trig == `SPMA_TRIG_INTV) ? par_next.period : 32'h00000000;
      med_reg  <= (par_next.filt == `SPMA_FILT_CUSTOM) ? par_next.med : 16'h0000;
      avg_reg  <= (par_next.filt == `SPMA_FILT_CUSTOM) ? par_next.avg : 16'h0000;
      ro_reg   <= link_next != SPMA_CLOSED;
      rate_reg <= link_next == SPMA_CONFIG;
    end
  end
  assign rsp_o          = rsp_reg;
  assign par_o          = par_reg;
  assign conn_refused_o = refu_reg;
  assign others_ro_o    = ro_reg;
  assign rate_reduce_o  = rate_reg;
  assign wr_status_o    = ws_reg;
  assign eff_period_o   = per_reg;
  assign eff_median_o   = med_reg;
  assign eff_average_o  = avg_reg;
  assign dist_o         = dist_reg;
  assign hold_o         = hold_reg;
  assign switch_o       = sw_reg;
  // Checks on the protocol decode and derived outputs
  chk_unit_filter: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && req_i.valid && req_i.unit != `SPMA_UNIT_ID |=> !rsp_o.valid) else $error("foreign unit answered");
  chk_write_gate: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && take && req_i.fc == `SPMA_FC_WR_MANY && req_i.addr > `SPMA_HR_LEAVE && link_reg != SPMA_CONFIG
    |=> rsp_o.exc && par_o == $past(par_reg)) else $error("write outside config mode");
  chk_count_match: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && take && req_i.fc == `SPMA_FC_RD_HR && len != 16'h0000 && q != len
    |=> rsp_o.exc && rsp_o.code == `SPMA_EXC_VALUE) else $error("partial read accepted");
  chk_trig_range: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    par_reg.trig <= `SPMA_TRIG_MAX && par_reg.filt <= `SPMA_FILT_MAX) else $error("selector out of range");
  chk_period_gate: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    eff_period_o != 32'h00000000 |-> par_reg.trig == `SPMA_TRIG_INTV) else $error("period outside interval mode");
  chk_enter_cfg: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && take && req_i.fc == `SPMA_FC_WR_ONE && req_i.addr == `SPMA_HR_ENTER && !other_cfg_i && !conn_close_i
    |=> link_reg == SPMA_CONFIG ##1 !ce_i || rate_reduce_o) else $error("config mode not entered");
  chk_status_done: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && pend_next |=> wr_status_o == `SPMA_WS_BUSY ##1 !ce_i || wr_status_o == `SPMA_WS_OK)
    else $error("write status sequence wrong");
  chk_substitute: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && !meas_valid_i && par_reg.inv == `SPMA_INV_FAR |=> dist_o == $past(par_reg.rend))
    else $error("far substitute missing");
  chk_second_conn: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    ce_i && conn_open_i && link_reg != SPMA_CLOSED |=> conn_refused_o) else $error("second connection taken");
  cov_param_write: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) pend_reg);
  cov_hold_run: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) hold_o ##1 !hold_o);
  cov_window: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) par_reg.sw == `SPMA_SW_WINDOW && switch_o);
endmodule

// ---- test/spma_client.sv ----
// Modbus client model that drives the parameter front end
`timescale 1ns/10ps
`include "spma_defines.svh"
module spma_client (
  input  wire logic                sys_clk_i,
  input  wire spma_pkg::spma_rsp_s rsp_i,
  output spma_pkg::spma_req_s      req_o,
  output logic                     conn_open_o,
  output logic                     conn_close_o
);
  import spma_pkg::*;
  // Idle link and no request at start
  initial begin
    req_o = '0;
    conn_open_o = 1'b0;
    conn_close_o = 1'b0;
  end
  // One-cycle pulse that opens or closes the link
  task automatic link(input logic open);
    @(posedge sys_clk_i);
    #1;
    conn_open_o = open;
    conn_close_o = !open;
    @(posedge sys_clk_i);
    #1;
    conn_open_o = 1'b0;
    conn_close_o = 1'b0;
  endtask
  // fixed port, count as given, low word first
  task automatic xfer(input logic [7:0] unit, input logic [7:0] fc, input logic [15:0] addr,
                      input logic [15:0] qty, input logic [31:0] wd, output logic got, output spma_rsp_s r);
    spma_req_s tmp;
    @(posedge sys_clk_i);
    #1;
    req_o = '{1'b1, `SPMA_TCP_PORT, unit, fc, addr, qty, wd};
    @(posedge sys_clk_i);
    #1;
    // Released fields flip so stale values cannot pass
    tmp = ~req_o;
    tmp.valid = 1'b0;
    req_o = tmp;
    got = 1'b0;
    r = '0;
    for (int i = 0; i < 4 && !got; i++) begin
      if (rsp_i.valid === 1'b1) begin
        got = 1'b1;
        r = rsp_i;
      end else begin
        @(posedge sys_clk_i);
        #1;
      end
    end
  endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the sensor parameter front end
`timescale 1ns/10ps
`include "spma_defines.svh"
module testbench;
  import spma_pkg::*;
  localparam int MS_CYC = 4; // Short millisecond keeps the hold test brief
  logic        sys_clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        other_cfg_i = 1'b0;
  logic [31:0] meas_i = '0;
  logic        meas_valid_i = 1'b0;
  logic        conn_open, conn_close, conn_refused_o, others_ro_o, rate_reduce_o, hold_o, switch_o;
  spma_req_s   req;
  spma_rsp_s   rsp;
  spma_par_s   par_o;
  logic [15:0] wr_status_o, eff_median_o, eff_average_o;
  logic [31:0] eff_period_o, dist_o, last;
  int          n_fail = 0;
  int          n_checks = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  spma_top #(.MS_CYC(MS_CYC)) dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .conn_open_i(conn_open), .conn_close_i(conn_close), .other_cfg_i(other_cfg_i), .req_i(req),
    .meas_i(meas_i), .meas_valid_i(meas_valid_i), .rsp_o(rsp), .par_o(par_o),
    .conn_refused_o(conn_refused_o), .others_ro_o(others_ro_o), .rate_reduce_o(rate_reduce_o),
    .wr_status_o(wr_status_o), .eff_period_o(eff_period_o), .eff_median_o(eff_median_o),
    .eff_average_o(eff_average_o), .dist_o(dist_o), .hold_o(hold_o), .switch_o(switch_o));
  spma_client client (.sys_clk_i(sys_clk_i), .rsp_i(rsp), .req_o(req), .conn_open_o(conn_open),
    .conn_close_o(conn_close));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Value compare, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Request with answer and code compare; read data left in last
  task automatic mb(input logic [7:0] fc, input logic [15:0] addr, input logic [15:0] qty,
                    input logic [31:0] wd, input logic [7:0] code);
    logic got;
    spma_rsp_s r;
    client.xfer(`SPMA_UNIT_ID, fc, addr, qty, wd, got, r);
    chk({31'h0, got}, 32'h1, "answer");
    chk({24'h0, r.code}, {24'h0, code}, "code");
    chk({31'h0, r.exc}, {31'h0, code != 8'h00}, "exception flag");
    chk({24'h0, r.fc}, {24'h0, fc}, "function echo");
    last = (qty == 16'h0001) ? {16'h0, r.rdata[15:0]} : r.rdata;
  endtask
  task automatic t_link();
    logic got;
    spma_rsp_s r;
    client.xfer(`SPMA_UNIT_ID, `SPMA_FC_RD_IR, `SPMA_IR_STATUS, 16'h1, '0, got, r);
    chk({31'h0, got}, 32'h0, "answer while closed");
    chk({16'h0, wr_status_o}, {16'h0, `SPMA_WS_OK}, "reset status");
    chk({16'h0, par_o.sw}, {16'h0, `SPMA_SW_POINT}, "reset switch mode");
    client.link(1'b1);
    chk({31'h0, others_ro_o}, 32'h1, "others read-only");
    client.link(1'b1);
    chk({31'h0, conn_refused_o}, 32'h1, "second link refused");
    client.xfer(8'h02, `SPMA_FC_RD_IR, `SPMA_IR_STATUS, 16'h1, '0, got, r);
    chk({31'h0, got}, 32'h0, "foreign unit answered");
  endtask
  task automatic t_gate();
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_TRIG, 16'h1, 32'h2, `SPMA_EXC_FUNC);
    tick(2);
    chk({16'h0, wr_status_o}, {16'h0, `SPMA_WS_ERR}, "status after refused");
    chk({16'h0, par_o.trig}, 32'h0, "trigger unchanged");
    other_cfg_i = 1'b1;
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_ENTER, 16'h1, 32'h0, `SPMA_EXC_FUNC);
    other_cfg_i = 1'b0;
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_ENTER, 16'h1, 32'h0, 8'h00);
    chk({31'h0, rate_reduce_o}, 32'h1, "rate reduced in config");
    mb(`SPMA_FC_RD_DI, `SPMA_DI_CFG, 16'h1, '0, 8'h00);
    chk(last, 32'h1, "config flag input");
    mb(`SPMA_FC_RD_HR, `SPMA_HR_LEAVE, 16'h1, '0, `SPMA_EXC_ADDR);
    mb(8'h05, `SPMA_HR_TRIG, 16'h1, '0, `SPMA_EXC_FUNC);
  endtask
  task automatic t_period();
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_PERIOD, 16'h2, 32'h0001_86A0, 8'h00);
    mb(`SPMA_FC_RD_HR, `SPMA_HR_PERIOD, 16'h2, '0, 8'h00);
    chk(last, 32'h0001_86A0, "period readback");
    mb(`SPMA_FC_RD_HR, `SPMA_HR_PERIOD, 16'h1, '0, `SPMA_EXC_VALUE);
    chk(eff_period_o, 32'h0, "period idle outside interval");
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_TRIG, 16'h1, 32'h2, 8'h00);
    tick(2);
    chk(eff_period_o, 32'h0001_86A0, "period in interval");
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_PERIOD, 16'h1, 32'h5, `SPMA_EXC_VALUE);
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_TRIG, 16'h1, 32'h3, `SPMA_EXC_VALUE);
    chk({16'h0, par_o.trig}, 32'h2, "trigger kept");
  endtask
  task automatic t_filter();
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_MED, 16'h1, 32'h7, 8'h00);
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_AVG, 16'h1, 32'h5, 8'h00);
    for (int f = 0; f <= 4; f++) begin
      mb(`SPMA_FC_WR_ONE, `SPMA_HR_FILT, 16'h1, f, 8'h00);
      tick(2);
      chk({16'h0, eff_median_o}, (f == 4) ? 32'h7 : 32'h0, "median length");
      chk({16'h0, eff_average_o}, (f == 4) ? 32'h5 : 32'h0, "average length");
    end
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_FILT, 16'h1, 32'h5, `SPMA_EXC_VALUE);
    mb(`SPMA_FC_RD_IR, `SPMA_IR_STATUS, 16'h1, '0, 8'h00);
    chk(last, {16'h0, `SPMA_WS_ERR}, "status register");
  endtask
  task automatic t_invalid();
    int cnt;
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_RSTART, 16'h2, 32'h64, 8'h00);
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_REND, 16'h2, 32'h1F4, 8'h00);
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_HOLD, 16'h1, 32'h2, 8'h00);
    for (int m = 0; m <= 2; m++) begin
      mb(`SPMA_FC_WR_ONE, `SPMA_HR_INV, 16'h1, m, 8'h00);
      meas_i = 32'h100;
      meas_valid_i = 1'b1;
      tick(2);
      meas_valid_i = 1'b0;
      cnt = 0;
      // Hold lasts exactly the programmed milliseconds
      for (int i = 0; i < 20; i++) begin
        tick(1);
        cnt += (hold_o === 1'b1);
      end
      chk(cnt, 2 * MS_CYC, "hold length");
      chk(dist_o, (m == 0) ? 32'h100 : (m == 1) ? 32'h64 : 32'h1F4, "substitute");
    end
  endtask
  task automatic t_switch();
    meas_i = 32'h100;
    meas_valid_i = 1'b1;
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_FAR, 16'h2, 32'h200, 8'h00);
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_POL, 16'h1, 32'h1, 8'h00);
    tick(3);
    chk({31'h0, switch_o}, 32'h1, "point active high");
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_NEAR, 16'h2, 32'h150, 8'h00);
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_SW, 16'h1, 32'h2, 8'h00);
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_POL, 16'h1, 32'h0, 8'h00);
    tick(3);
    chk({31'h0, switch_o}, 32'h1, "window outside, active low");
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_SW, 16'h1, 32'h3, `SPMA_EXC_VALUE);
  endtask
  task automatic t_zero();
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_ZERO, 16'h2, 32'hFFF8_5EE0, 8'h00);
    chk(par_o.zero, 32'hFFF8_5EE0, "negative zero at limit");
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_ZERO, 16'h2, 32'h0007_A121, `SPMA_EXC_VALUE);
    chk(par_o.zero, 32'hFFF8_5EE0, "zero kept");
    mb(`SPMA_FC_WR_ONE, `SPMA_HR_LEAVE, 16'h1, 32'h0, 8'h00);
    chk({31'h0, rate_reduce_o}, 32'h0, "rate restored");
    mb(`SPMA_FC_WR_MANY, `SPMA_HR_HOLD, 16'h1, 32'h9, `SPMA_EXC_FUNC);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reset for six cycles, then the scenarios in order
  initial begin
    tick(6);
    nrst_i = 1'b1;
    t_link();
    t_gate();
    t_period();
    t_filter();
    t_invalid();
    t_switch();
    t_zero();
    tally_and_finish();
  end
endmodule
